// File: logic/cfbu_consts.svh
// cfbu_consts.svh: encodings, field positions and fixed values
// of the compact and floating-point branch unit.
// assumes 32-bit instruction words with the major opcode on top.
`ifndef CFBU_CONSTS_SVH
`define CFBU_CONSTS_SVH

// major opcodes
`define CFBU_OP_COMPACT_BRANCH 6'h32
`define CFBU_OP_COMPACT_LINK 6'h3A
`define CFBU_OP_FP_MAJOR 6'h11

// sub-opcodes under the floating-point major opcode
`define CFBU_SUB_BIT0_ZERO 5'h09
`define CFBU_SUB_BIT0_NONZERO 5'h0D
`define CFBU_SUB_COND 5'h08

// field positions
`define CFBU_OP_HI 31
`define CFBU_OP_LO 26
`define CFBU_SUB_HI 25
`define CFBU_SUB_LO 21
`define CFBU_FT_HI 20
`define CFBU_FT_LO 16
`define CFBU_CC_HI 20
`define CFBU_CC_LO 18
`define CFBU_ND_BIT 17
`define CFBU_TF_BIT 16
`define CFBU_OFF16_HI 15
`define CFBU_OFF26_HI 25

// fixed values
`define CFBU_LINK_REG 5'h1F
`define CFBU_CC_ZERO 3'h0
`define CFBU_INSTR_BYTES 4
`define CFBU_OFF_SHIFT 2
`define CFBU_OFF16_W 16
`define CFBU_OFF26_W 26

`endif

// File: logic/cfbu_pkg.sv
// cfbu_pkg: types shared by the branch unit files.
// assumes nothing beyond a SystemVerilog elaborator.
package cfbu_pkg;

    // gray along normal -> slot -> normal; normal -> kill -> normal flips both bits
    typedef enum logic [1:0]
    {
        CFBU_ST_NORMAL = 2'b00,
        CFBU_ST_SLOT = 2'b01,
        CFBU_ST_KILL = 2'b11
    } cfbu_state_type;

endpackage

// File: logic/cfbu_target_add.sv
// cfbu_target_add: sequential address and pc-relative target.
// assumes the offset field is a word offset, shifted two places.
`timescale 1ns/1ps
`include "cfbu_consts.svh"

module cfbu_target_add
#(
    parameter int ADDR_W = 64,
    parameter int OFF_W = 16
)
(
    input wire logic [ADDR_W-1:0] pc,        // branch address
    input wire logic [OFF_W-1:0] offset,     // raw offset field
    output logic [ADDR_W-1:0] seq_pc,        // pc plus one word
    output logic [ADDR_W-1:0] target         // branch target
);

    localparam int DISP_W = OFF_W + `CFBU_OFF_SHIFT;

    logic [DISP_W-1:0] disp;
    logic [ADDR_W-1:0] disp_ext;

    assign disp = {offset, {`CFBU_OFF_SHIFT{1'b0}}};
    assign disp_ext = {{(ADDR_W-DISP_W){disp[DISP_W-1]}}, disp};
    assign seq_pc = pc + ADDR_W'(`CFBU_INSTR_BYTES);
    // carry out of the top bit is dropped: targets wrap (see RQ20)
    assign target = seq_pc + disp_ext;

endmodule

// File: logic/cfbu_branch_unit.sv
// cfbu_branch_unit: decode and resolve of compact branches,
// fp register bit0 branches and legacy fp condition branches.
// assumes the fetch pipeline issues one instruction per valid,
// answers fpr_sel with fpr_bit0 in the same cycle, and flags
// every other control transfer it decodes on issue_other_cti.
//
// Behaviour
// RQ1: compact branch offset is bits 25..0, shifted two, signed.
// RQ2: compact branch has no delay slot; taken target is pc+4+offset.
// RQ3: compact branches always taken, no forbidden slot check after.
// RQ4: compact branch decoded in the old second_coprocessor_major word load encoding.
// RQ5: compact branch-link decoded in the old second_coprocessor_major word store encoding.
// RQ6: compact branch-link writes register 31 with pc+4.
// RQ7: bit0-zero fp branch true when fp register bit 0 is zero.
// RQ8: bit0-nonzero fp branch true when selected bit 0 is one.
// RQ9: false fp register branch falls through sequentially.
// RQ10: fp register branch: 16-bit offset shifted two, slot runs first.
// RQ11: fp register branch with fp unit disabled raises unusable.
// RQ12: fp register branches ignore format and use only bit 0.
// RQ13: control transfer in a delay slot raises reserved.
// RQ14: fp register branches never raise reserved when fpu present; the code raises reserved for one that sits in a delay slot (RQ13).
// RQ15: condition-false branch with cc zero runs slot then branches.
// RQ16: legacy branch picks one of eight codes by bits 20..18.
// RQ17: newer-release cores decode legacy condition branches reserved.
// RQ18: legacy branch: unusable if fpu disabled, reserved if unsupported.
// RQ19: tf picks polarity; nd picks likely; untaken likely kills slot.
// RQ20: target sums wrap at full address width.
`timescale 1ns/1ps
`include "cfbu_consts.svh"

module cfbu_branch_unit
    import cfbu_pkg::*;
#(
    parameter int ADDR_W = 64,
    parameter int CC_N = 8
)
(
    input wire logic core_clk,               // core clock
    input wire logic rst_b,                  // async reset, low
    input wire logic pipe_flush,             // drop pending branch
    input wire logic issue_valid,            // instruction issued
    input wire logic [31:0] issue_instr,     // instruction word
    input wire logic [ADDR_W-1:0] issue_pc,  // its address
    input wire logic issue_other_cti,        // other jump or return
    input wire logic fpu_implemented,        // fp unit present
    input wire logic fpu_enabled,            // fp access enabled
    input wire logic legacy_cc_supported,    // old cc branches kept
    input wire logic single_cc_only,         // one cond code only
    input wire logic fpr_bit0,               // bit 0 of fpr_sel
    input wire logic [CC_N-1:0] fp_cond_codes, // condition codes
    output logic [4:0] fpr_sel,              // fp register to read
    output logic res_valid,                  // result cycle
    output logic own_branch,                 // was one of ours
    output logic redirect_valid,             // load redirect_pc
    output logic [ADDR_W-1:0] redirect_pc,   // new fetch address
    output logic squash_next,                // drop next instruction
    output logic slot_nullify,               // slot cancelled
    output logic link_we,                    // write link register
    output logic [4:0] link_idx,             // link register index
    output logic [ADDR_W-1:0] link_data,     // return address
    output logic exc_cop_unusable,           // coprocessor unusable
    output logic exc_reserved                // reserved instruction
);

    ////////////////////////////////////////////////////////////////
    // field extraction

    logic [5:0] op;
    logic [4:0] sub;
    logic [2:0] cc_sel;
    logic nd_flag;
    logic tf_flag;
    logic [`CFBU_OFF16_W-1:0] off16;
    logic [`CFBU_OFF26_W-1:0] off26;

    assign op = issue_instr[`CFBU_OP_HI:`CFBU_OP_LO];
    assign sub = issue_instr[`CFBU_SUB_HI:`CFBU_SUB_LO];
    assign cc_sel = issue_instr[`CFBU_CC_HI:`CFBU_CC_LO];
    assign nd_flag = issue_instr[`CFBU_ND_BIT];
    assign tf_flag = issue_instr[`CFBU_TF_BIT];
    assign off16 = issue_instr[`CFBU_OFF16_HI:0];
    assign off26 = issue_instr[`CFBU_OFF26_HI:0]; // see RQ1
    // register bit0 branches read the register named by bits 20..16
    assign fpr_sel = issue_instr[`CFBU_FT_HI:`CFBU_FT_LO]; // see RQ8

    ////////////////////////////////////////////////////////////////
    // target adders

    logic [ADDR_W-1:0] seq_pc;
    logic [ADDR_W-1:0] target26;
    logic [ADDR_W-1:0] target16;

    // see RQ1
    cfbu_target_add
    #(
        .ADDR_W(ADDR_W),
        .OFF_W(`CFBU_OFF26_W)
    )
    u_add26
    (
        .pc(issue_pc),
        .offset(off26),
        .seq_pc(seq_pc),
        .target(target26)
    );

    // see RQ10
    cfbu_target_add
    #(
        .ADDR_W(ADDR_W),
        .OFF_W(`CFBU_OFF16_W)
    )
    u_add16
    (
        .pc(issue_pc),
        .offset(off16),
        .seq_pc(),
        .target(target16)
    );

    ////////////////////////////////////////////////////////////////
    // decode

    logic is_cb;
    logic is_cbl;
    logic is_fp_major;
    logic is_eqz;
    logic is_nez;
    logic is_legacy;
    logic own_cti;

    // the old second_coprocessor_major load/store live under the second coprocessor
    // major now, so these opcodes mean compact branches only
    assign is_cb = op == `CFBU_OP_COMPACT_BRANCH; // see RQ4
    assign is_cbl = op == `CFBU_OP_COMPACT_LINK; // see RQ5
    assign is_fp_major = op == `CFBU_OP_FP_MAJOR;
    assign is_eqz = is_fp_major && sub == `CFBU_SUB_BIT0_ZERO;
    assign is_nez = is_fp_major && sub == `CFBU_SUB_BIT0_NONZERO;
    assign is_legacy = is_fp_major && sub == `CFBU_SUB_COND;
    assign own_cti = is_cb | is_cbl | is_eqz | is_nez | is_legacy;

    ////////////////////////////////////////////////////////////////
    // conditions

    logic reg_cond;
    logic cc_bit;
    logic legacy_cond;

    // only bit 0 enters, whatever format produced it (see RQ12)
    assign reg_cond = is_eqz ? ~fpr_bit0 : fpr_bit0; // see RQ7
    assign cc_bit = fp_cond_codes[cc_sel]; // see RQ16
    // tf=0 tests for a clear code, tf=1 for a set one
    assign legacy_cond = cc_bit == tf_flag; // see RQ15 // see RQ19

    ////////////////////////////////////////////////////////////////
    // state

    cfbu_state_type state_r;
    cfbu_state_type state_nxt;
    logic pend_taken_r;
    logic [ADDR_W-1:0] pend_target_r;

    logic go;
    logic in_slot;
    logic in_kill;
    logic slot_cti_err;
    logic legacy_bad;
    logic reg_unusable;
    logic legacy_unusable;
    logic fault_cu;
    logic fault_ri;
    logic clean;

    assign go = issue_valid && !pipe_flush;
    assign in_slot = state_r == CFBU_ST_SLOT;
    assign in_kill = state_r == CFBU_ST_KILL;

    // a cancelled likely slot is never examined, so no check there
    assign slot_cti_err = in_slot && (own_cti || issue_other_cti); // see RQ13

    // cc field must be zero on single-code cores
    assign legacy_bad = !legacy_cc_supported || !fpu_implemented
        || (single_cc_only && cc_sel != `CFBU_CC_ZERO); // see RQ17

    // register branches see only unusable outside a delay slot (see RQ14)
    assign reg_unusable = (is_eqz || is_nez) && !fpu_enabled; // see RQ11
    assign legacy_unusable = is_legacy && !legacy_bad
        && !fpu_enabled; // see RQ18

    assign fault_ri = !in_kill
        && (slot_cti_err || (is_legacy && legacy_bad)); // see RQ18
    assign fault_cu = !in_kill && !slot_cti_err
        && (reg_unusable || legacy_unusable);
    assign clean = go && !in_kill && !fault_ri && !fault_cu;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CFBU_ST_NORMAL:
            begin
                if (clean && (is_eqz || is_nez))
                begin
                    state_nxt = CFBU_ST_SLOT; // see RQ10
                end
                else if (clean && is_legacy)
                begin
                    // likely and false: slot is cancelled (see RQ19)
                    if (nd_flag && !legacy_cond)
                    begin
                        state_nxt = CFBU_ST_KILL;
                    end
                    else
                    begin
                        state_nxt = CFBU_ST_SLOT;
                    end
                end
                // compact branches leave no slot behind (see RQ3)
            end
            CFBU_ST_SLOT:
            begin
                if (go)
                begin
                    state_nxt = CFBU_ST_NORMAL;
                end
            end
            CFBU_ST_KILL:
            begin
                if (go)
                begin
                    state_nxt = CFBU_ST_NORMAL;
                end
            end
            default:
            begin
                state_nxt = CFBU_ST_NORMAL;
            end
        endcase
        if (pipe_flush)
        begin
            state_nxt = CFBU_ST_NORMAL;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= CFBU_ST_NORMAL;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // pending outcome of a delay-slot branch, applied after the slot
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_taken_r <= 1'b0;
            pend_target_r <= '0;
        end
        else if (clean && state_r == CFBU_ST_NORMAL)
        begin
            if (is_eqz || is_nez)
            begin
                // false condition falls through (see RQ9)
                pend_taken_r <= reg_cond;
                pend_target_r <= target16;
            end
            else if (is_legacy)
            begin
                pend_taken_r <= legacy_cond;
                pend_target_r <= target16;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs, all registered one cycle after issue

    logic compact_go;
    logic slot_done;

    assign compact_go = clean && !in_slot && (is_cb || is_cbl);
    // slot redirect is held back if the slot itself faulted
    assign slot_done = go && in_slot && !fault_ri;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            res_valid <= 1'b0;
            own_branch <= 1'b0;
        end
        else
        begin
            res_valid <= go;
            own_branch <= go && !in_kill && own_cti;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            redirect_valid <= 1'b0;
            redirect_pc <= '0;
        end
        else if (compact_go)
        begin
            redirect_valid <= 1'b1; // see RQ2
            redirect_pc <= target26; // see RQ2
        end
        else if (slot_done && pend_taken_r)
        begin
            // slot has run, now go to target (see RQ10)
            redirect_valid <= 1'b1;
            redirect_pc <= pend_target_r;
        end
        else
        begin
            redirect_valid <= 1'b0;
        end
    end

    // the word after a compact branch is already fetched; kill it
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            squash_next <= 1'b0;
        end
        else
        begin
            squash_next <= compact_go; // see RQ2
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slot_nullify <= 1'b0;
        end
        else
        begin
            slot_nullify <= go && in_kill; // see RQ19
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            link_we <= 1'b0;
            link_idx <= 5'h00;
            link_data <= '0;
        end
        else if (compact_go && is_cbl)
        begin
            link_we <= 1'b1; // see RQ6
            link_idx <= `CFBU_LINK_REG; // see RQ6
            link_data <= seq_pc; // see RQ6
        end
        else
        begin
            link_we <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            exc_cop_unusable <= 1'b0;
            exc_reserved <= 1'b0;
        end
        else
        begin
            exc_cop_unusable <= go && fault_cu; // see RQ11
            exc_reserved <= go && fault_ri; // see RQ13
        end
    end

endmodule

// File: dv/cfbu_branch_unit_asserts.sv
// cfbu_branch_unit_asserts: port-level timing checks of the unit.
// assumes it is bound to cfbu_branch_unit, inputs zero in reset.
`timescale 1ns/1ps
module cfbu_branch_unit_asserts
#(
    parameter int ADDR_W = 64
)
(
    input wire logic core_clk,               // core clock
    input wire logic rst_b,                  // async reset, low
    input wire logic pipe_flush,             // flush
    input wire logic issue_valid,            // issue strobe
    input wire logic [31:0] issue_instr,     // instruction
    input wire logic [ADDR_W-1:0] issue_pc,  // its address
    input wire logic fpu_enabled,            // fp access
    input wire logic legacy_cc_supported,    // old branches
    input wire logic res_valid,              // result cycle
    input wire logic own_branch,             // ours
    input wire logic redirect_valid,         // redirect
    input wire logic [ADDR_W-1:0] redirect_pc, // target
    input wire logic squash_next,            // drop next
    input wire logic slot_nullify,           // slot killed
    input wire logic link_we,                // link write
    input wire logic [4:0] link_idx,         // link index
    input wire logic [ADDR_W-1:0] link_data, // link value
    input wire logic exc_cop_unusable,       // unusable
    input wire logic exc_reserved            // reserved
);
    logic go, cgo, fpb, leg;
    logic [ADDR_W-1:0] ctgt;
    assign go = issue_valid && !pipe_flush;
    // both compact opcodes share 11x010 in the major field
    assign cgo = go && issue_instr[31:30] == 2'h3
        && issue_instr[28:26] == 3'h2;
    // bit0-zero 01001 and bit0-nonzero 01101 differ only in bit 23
    assign fpb = issue_instr[31:26] == 6'h11
        && issue_instr[25:24] == 2'h1 && issue_instr[22:21] == 2'h1;
    assign leg = issue_instr[31:21] == 11'h228;
    // 28-bit displacement sign-extended before the add, carry dropped
    assign ctgt = issue_pc + ADDR_W'(4)
        + {{(ADDR_W-28){issue_instr[25]}}, issue_instr[25:0], 2'h0};

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_result_latency: assert property (
        res_valid == $past(go)) else $error("result cycle off");
    chk_compact_target: assert property (
        cgo |=> exc_reserved || slot_nullify || (redirect_valid
        && squash_next && redirect_pc == $past(ctgt)))
        else $error("bad compact target");
    chk_link_write: assert property (
        cgo && issue_instr[31:26] == 6'h3A |=> exc_reserved || slot_nullify
        || (link_we && link_idx == 5'h1F
        && link_data == $past(issue_pc) + ADDR_W'(4)))
        else $error("bad link write");
    chk_cop_unusable: assert property (
        go && fpb && !fpu_enabled |=> slot_nullify
        || (exc_cop_unusable != exc_reserved && !redirect_valid))
        else $error("no unusable fault");
    chk_legacy_gone: assert property (
        go && leg && !legacy_cc_supported |=> slot_nullify
        || (exc_reserved && !exc_cop_unusable))
        else $error("legacy not reserved");
    chk_fault_quiet: assert property (
        exc_reserved || exc_cop_unusable |-> !redirect_valid && !link_we
        && !squash_next) else $error("fault with effect");
    chk_squash_cause: assert property (
        squash_next |-> $past(cgo)) else $error("squash without compact");
    chk_result_gated: assert property (
        own_branch || redirect_valid || link_we || slot_nullify
        |-> res_valid) else $error("pulse outside result");
    chk_nullify_quiet: assert property (
        slot_nullify |-> !redirect_valid && !exc_reserved)
        else $error("nullified slot acted");

    cover property (cgo);
    cover property (slot_nullify);
    cover property (exc_cop_unusable);
    cover property (redirect_valid && !squash_next);
endmodule

bind cfbu_branch_unit cfbu_branch_unit_asserts #(.ADDR_W(ADDR_W)) i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .pipe_flush(pipe_flush),
    .issue_valid(issue_valid), .issue_instr(issue_instr),
    .issue_pc(issue_pc), .fpu_enabled(fpu_enabled),
    .legacy_cc_supported(legacy_cc_supported), .res_valid(res_valid),
    .own_branch(own_branch), .redirect_valid(redirect_valid),
    .redirect_pc(redirect_pc), .squash_next(squash_next),
    .slot_nullify(slot_nullify), .link_we(link_we), .link_idx(link_idx),
    .link_data(link_data), .exc_cop_unusable(exc_cop_unusable),
    .exc_reserved(exc_reserved));

// File: dv/cfbu_fp_model.sv
// cfbu_fp_model: floating-point side seen by the branch unit.
// assumes the bench loads contents only while no branch is pending.
`timescale 1ns/1ps
module cfbu_fp_model
(
    input wire logic core_clk,       // core clock
    input wire logic ld,             // take new contents
    input wire logic [31:0] ld_bits, // bit 0 of each register
    input wire logic [7:0] ld_cc,    // new condition codes
    input wire logic [4:0] fpr_sel,  // register asked for
    output logic fpr_bit0,           // its bit 0
    output logic [7:0] fp_cond_codes // codes to the unit
);
    logic [31:0] bits_r;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk)
    begin
        if (ld)
        begin
            bits_r <= ld_bits;
            fp_cond_codes <= ld_cc;
        end
    end

    // upper register bits are never modelled: only bit 0 is consumed
    assign fpr_bit0 = bits_r[fpr_sel];
endmodule

// File: dv/tb_compact_and_fpu_branch_unit.sv
// tb_compact_and_fpu_branch_unit: random and corner branch issues.
// assumes the checker binds itself; fp side comes from cfbu_fp_model.
`timescale 1ns/1ps
module tb_compact_and_fpu_branch_unit;
    logic core_clk = 1'b0, rst_b = 1'b0, pipe_flush = 1'b0;
    logic issue_valid = 1'b0, issue_other_cti = 1'b0, ld = 1'b0;
    logic fpu_implemented = 1'b1, fpu_enabled = 1'b1;
    logic legacy_cc_supported = 1'b1, single_cc_only = 1'b0;
    logic [31:0] issue_instr = 32'h0, ld_bits = 32'h0;
    logic [63:0] issue_pc = 64'h0, redirect_pc, link_data;
    logic [7:0] ld_cc = 8'h0, fp_cond_codes;
    logic [4:0] fpr_sel, link_idx;
    logic fpr_bit0, res_valid, own_branch, redirect_valid, squash_next;
    logic slot_nullify, link_we, exc_cop_unusable, exc_reserved;
    logic [31:0] seed = 32'h5A34;
    int error_cnt = 0, n_compared = 0;

    cfbu_branch_unit i_cfbu_branch_unit (.core_clk, .rst_b, .pipe_flush,
        .issue_valid, .issue_instr, .issue_pc, .issue_other_cti,
        .fpu_implemented, .fpu_enabled, .legacy_cc_supported,
        .single_cc_only, .fpr_bit0, .fp_cond_codes, .fpr_sel, .res_valid,
        .own_branch, .redirect_valid, .redirect_pc, .squash_next,
        .slot_nullify, .link_we, .link_idx, .link_data, .exc_cop_unusable,
        .exc_reserved);
    cfbu_fp_model i_cfbu_fp_model (.core_clk, .ld, .ld_bits, .ld_cc,
        .fpr_sel, .fpr_bit0, .fp_cond_codes);

    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [63:0] tgt(input logic [63:0] pc,
        input logic [25:0] off, input logic wide);
        if (wide)
            return pc + 64'h4 + {{36{off[25]}}, off, 2'h0};
        return pc + 64'h4 + {{46{off[15]}}, off[15:0], 2'h0};
    endfunction

    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // the strobe drops at the taking edge so nothing is issued twice
    task iss(input logic [31:0] ins, input logic [63:0] pc,
        input logic c, input logic f);
        @(posedge core_clk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        issue_pc <= pc;
        issue_other_cti <= c;
        pipe_flush <= f;
        @(posedge core_clk);
        issue_valid <= 1'b0;
        pipe_flush <= 1'b0;
        #1;
    endtask

    task load(input logic [31:0] b);
        @(posedge core_clk);
        ld <= 1'b1;
        ld_bits <= b;
        ld_cc <= b[15:8];
        @(posedge core_clk);
        ld <= 1'b0;
    endtask

    task cfg(input logic en, sup, one, imp);
        @(posedge core_clk);
        fpu_enabled <= en;
        legacy_cc_supported <= sup;
        single_cc_only <= one;
        fpu_implemented <= imp;
    endtask

    task final_report();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    initial
    begin
        #100000;
        error_cnt++;
        final_report();
    end

    initial
    begin
        logic [63:0] pc;
        logic [31:0] r, bits;
        logic [25:0] off;
        logic [1:0] k;
        logic b, cnd, nul, control_transfer_instr;
        load(32'h0);
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 40; i++)
        begin
            r = rnd();
            pc = {rnd(), r[31:2], 2'h0};
            // first two hit both wrap directions of the target add
            if (i < 2)
                pc = i ? 64'hFFFFFFFFFFFFFFF8 : 64'h0;
            off = i < 2 ? {~i[0], {25{i[0]}}} : r[25:0];
            b = i[0];
            iss({b ? 6'h3A : 6'h32, off}, pc, 1'b0, 1'b0);
            chk(redirect_valid && squash_next && own_branch
                && res_valid, 1'b1);
            chk(redirect_pc, tgt(pc, off, 1'b1));
            chk(link_we, b);
            chk(b ? link_data : pc + 64'h4, pc + 64'h4);
            chk(b ? link_idx : 5'h1F, 5'h1F);
            iss(32'h0, pc + 64'h4, 1'b1, 1'b0);
            chk({exc_reserved, redirect_valid}, 2'h0);
        end
        iss({6'h32, 26'h0}, 64'h0, 1'b0, 1'b1);
        chk(res_valid, 1'b0);
        for (int i = 0; i < 64; i++)
        begin
            bits = rnd();
            load(bits);
            r = rnd();
            pc = {rnd(), r[31:2], 2'h0};
            k = i[1:0];
            cnd = k[1] ? bits[8 + r[20:18]] == r[16] : bits[r[20:16]] == k[0];
            nul = k[1] && r[17] && !cnd;
            control_transfer_instr = i % 7 == 3 && !nul;
            iss({6'h11, k[1] ? 5'h08 : {2'h1, k[0], 2'h1}, r[20:0]}, pc,
                1'b0, 1'b0);
            chk({own_branch, exc_reserved, exc_cop_unusable}, 3'h4);
            iss(32'h0, pc + 64'h4, control_transfer_instr, 1'b0);
            chk({slot_nullify, exc_reserved, redirect_valid},
                {nul, control_transfer_instr, cnd && !control_transfer_instr});
            if (cnd && !control_transfer_instr)
                chk(redirect_pc, tgt(pc, r[25:0], 1'b0));
        end
        for (int j = 0; j < 5; j++)
        begin
            cfg(j > 1, j != 2, j == 3, j != 4);
            iss({6'h11, j ? 5'h08 : 5'h09, 21'hC0000}, 64'h1000, 1'b0,
                1'b0);
            chk({exc_reserved, exc_cop_unusable},
                j < 2 ? 2'h1 : 2'h2);
            iss(32'h0, 64'h1004, 1'b1, 1'b0);
            chk({exc_reserved, redirect_valid}, 2'h0);
        end
        final_report();
    end
endmodule
